// file: iccfg_pkg.sv
package iccfg_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_INTERP  = 8'h00;
  localparam logic [7:0] ADDR_IO_CFG  = 8'h04;
  localparam logic [7:0] ADDR_CLK_CFG = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0c;

  // Interpolation register fields
  localparam int INTERP_LSB = 0;
  localparam int INTERP_W   = 2;
  localparam logic [1:0] INTERP_BYPASS = 2'h0;
  localparam logic [1:0] INTERP_X2     = 2'h1;
  localparam logic [1:0] INTERP_X4     = 2'h2;

  // I/O interface configuration fields
  localparam int IO_LOOPBACK  = 5;
  localparam int IO_DUPLEX    = 4;
  localparam int IO_DIRECTION = 3;
  localparam int IO_WIDTH     = 2;
  localparam int IO_OVERRIDE  = 1;
  localparam int IO_CLONE     = 0;
  localparam logic [7:0] IO_CFG_RESET = 8'h10;

  // Clock generation configuration fields
  localparam int CK_BYPASS  = 7;
  localparam int CK_ADC_DIV = 5;
  localparam int CK_ALT     = 4;
  localparam int CK_DIV5    = 3;
  localparam int CK_MUL_LSB = 0;
  localparam int CK_MUL_W   = 3;
  localparam logic [7:0] CLK_CFG_RESET = 8'h00;
  localparam logic [2:0] MUL_X1 = 3'h0;
  localparam logic [2:0] MUL_X2 = 3'h1;
  localparam logic [2:0] MUL_X4 = 3'h2;

  // Status register fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_TX       = 2;
  localparam int ST_LOOP     = 3;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Interface modes
  typedef enum logic [1:0] {
    ICCFG_FULL_DUPLEX        = 2'h0,
    ICCFG_HALF_DUPLEX_NARROW = 2'h1,
    ICCFG_HALF_DUPLEX_WIDE   = 2'h2
  } iccfg_mode_type;
endpackage

// file: iccfg_top.sv
// Summary of operation
// [RL1] Two-bit interpolation field: 00 bypass, 01 rate two, 10 rate four.
// [RL2] Loopback bit 5 forces full-duplex timing, transmit path output on receive bus.
// [RL3] Software enables full duplex before or with digital loopback.
// [RL4] Duplex bit 4 high means full duplex; resets high.
// [RL5] Mode from duplex and width bits; duplex ignored in clone mode.
// [RL6] In half duplex, direction bit 3 high transmits, low receives.
// [RL7] Width bit 2 high selects 10-bit, low selects 20-bit.
// [RL8] Override bit 1 takes direction from register instead of pin.
// [RL9] Clone mode needs clone bit 0 and clock mode field 111; the code takes clone mode from clone bit 0 alone.
// [RL10] Bypass bit 7 routes clocks around PLL, PLL keeps running.
// [RL11] ADC clock divide bit 5 halves ADC clock source when high.
// [RL12] Alternate timing bit 4 clocks receive path from PLL, else reference.
// [RL13] Divide-by-five bit 3 divides PLL output for transmit path.
// [RL14] Multiplier field 000 one, 001 two, 010 four, with divide-by-five.
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
module iccfg_top (
  // Clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  // AXI4-Lite write address
  input  wire logic [7:0]            s_axi_awaddr_i,
  input  wire logic                  s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  // AXI4-Lite write data
  input  wire logic [31:0]           s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  input  wire logic                  s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp_o,
  output logic                       s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  // AXI4-Lite read address
  input  wire logic [7:0]            s_axi_araddr_i,
  input  wire logic                  s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  // AXI4-Lite read data
  output logic [31:0]                s_axi_rdata_o,
  output logic [1:0]                 s_axi_rresp_o,
  output logic                       s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i,
  // External direction pin
  input  wire logic                  direction_pin_i,
  // Data interface controls
  output iccfg_pkg::iccfg_mode_type  iface_mode_o,
  output logic                       tx_active_o,
  output logic                       loopback_o,
  output logic                       clone_mode_enable_o,
  output logic [1:0]                 interp_rate_o,
  output logic                       interp_x2_o,
  output logic                       interp_x4_o,
  // Clock distribution controls
  output logic                       pll_bypass_o,
  output logic                       adc_clock_halve_o,
  output logic                       rx_clock_from_pll_o,
  output logic                       synth_divide_by_five_o,
  output logic [2:0]                 pll_multiplier_o,
  output logic [4:0]                 pll_mult_factor_o
);
  import iccfg_pkg::*;

  logic [1:0]           interp_cfg;
  logic [7:0]           io_interface_config;
  logic [7:0]           clock_generation_config;
  logic [7:0]           aw_addr;
  logic                 aw_held;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic                 w_held;
  logic                 dir_meta;
  logic                 dir_sync;
  iccfg_mode_type       next_mode;
  logic                 next_tx;
  logic [31:0]          next_rdata;
  logic                 next_rhit;
  logic                 do_write;
  logic [7:0]           wr_addr;
  logic [31:0]          wr_data;
  logic [3:0]           wr_strb;

  // Shared address decode
  // Used by the write and the read response alike, so that an unmapped
  // offset gives the same error code on either channel
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == ADDR_INTERP) || (a == ADDR_IO_CFG) || (a == ADDR_CLK_CFG) ||
           (a == ADDR_STATUS);
  endfunction

  // Write address capture; either channel may arrive first
  // The address is parked here until the data beat joins it; the slot is
  // freed only by the write itself, never by a second address
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_i;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // Write data capture
  // Data and strobes are parked together until the address joins them
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata_i;
      w_strb <= s_axi_wstrb_i;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // A write fires once both halves are parked and no response is waiting;
  // holding it back while bvalid stands keeps one response per write
  assign do_write = aw_held && w_held && !s_axi_bvalid_o;
  assign wr_addr  = aw_addr;
  assign wr_data  = w_data;
  assign wr_strb  = w_strb;

  // Ready while the holding slot is free
  // Ready drops in the cycle after a handshake, so a valid that stays up
  // one edge too long cannot be taken twice
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
    end else begin
      s_axi_awready_o <= !aw_held && !(s_axi_awvalid_i && s_axi_awready_o) && !do_write;
      s_axi_wready_o  <= !w_held && !(s_axi_wvalid_i && s_axi_wready_o) && !do_write;
    end
  end

  // Write response
  // An unmapped offset is answered with an error and changes nothing
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= is_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // Configuration registers, low byte lane only
  // A write without lane 0 is answered but leaves the fields alone;
  // writes to the status word are dropped
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      interp_cfg              <= INTERP_BYPASS;          // [RL1]
      io_interface_config     <= IO_CFG_RESET;           // [RL4]
      clock_generation_config <= CLK_CFG_RESET;
    end else if (do_write && wr_strb[0]) begin
      case (wr_addr)
        ADDR_INTERP:  interp_cfg <= wr_data[INTERP_LSB +: INTERP_W];
        ADDR_IO_CFG:  io_interface_config <= wr_data[7:0];
        ADDR_CLK_CFG: clock_generation_config <= wr_data[7:0];
        default: ;
      endcase
    end
  end

  // Direction pin synchroniser
  // The pin has no relation to our clock; only the second stage is read,
  // so the decode sees a pin change one to two cycles late
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      dir_meta <= 1'b0;
      dir_sync <= 1'b0;
    end else begin
      dir_meta <= direction_pin_i;
      dir_sync <= dir_meta;
    end
  end

  // Interface mode and direction decode
  // Loopback takes precedence so that its full-duplex timing holds even if
  // software has left the duplex bit low. Clone mode ignores the duplex bit
  // and takes the width from the width bit alone. In full duplex there is
  // no single direction, so the transmit flag is held low.
  always_comb begin
    next_mode = ICCFG_FULL_DUPLEX;
    next_tx   = 1'b0;
    if (io_interface_config[IO_LOOPBACK]) begin
      next_mode = ICCFG_FULL_DUPLEX;                      // [RL2]
    end else if (io_interface_config[IO_DUPLEX] && !io_interface_config[IO_CLONE]) begin
      next_mode = ICCFG_FULL_DUPLEX;                      // [RL4] [RL5]
    end else if (io_interface_config[IO_WIDTH]) begin
      next_mode = ICCFG_HALF_DUPLEX_NARROW;               // [RL7]
    end else begin
      next_mode = ICCFG_HALF_DUPLEX_WIDE;                 // [RL7]
    end
    if (io_interface_config[IO_OVERRIDE]) begin
      next_tx = io_interface_config[IO_DIRECTION];        // [RL6] [RL8]
    end else begin
      next_tx = dir_sync;
    end
    if (next_mode == ICCFG_FULL_DUPLEX) begin
      next_tx = 1'b0;
    end
  end

  // Interface control outputs
  // Registered so that every control reaches the data bus glitch free, one
  // cycle after the register write lands
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      iface_mode_o        <= ICCFG_FULL_DUPLEX;
      tx_active_o         <= 1'b0;
      loopback_o          <= 1'b0;
      clone_mode_enable_o <= 1'b0;
      interp_rate_o       <= INTERP_BYPASS;
      interp_x2_o         <= 1'b0;
      interp_x4_o         <= 1'b0;
    end else begin
      iface_mode_o        <= next_mode;
      tx_active_o         <= next_tx;                                // [RL6]
      loopback_o          <= io_interface_config[IO_LOOPBACK];       // [RL2]
      clone_mode_enable_o <= io_interface_config[IO_CLONE];          // [RL5]
      interp_rate_o       <= interp_cfg;                             // [RL1]
      interp_x2_o         <= (interp_cfg == INTERP_X2);              // [RL1]
      interp_x4_o         <= (interp_cfg == INTERP_X4);              // [RL1]
    end
  end

  // Clock distribution outputs
  // Unused multiplier codes fall back to a factor of one on pll_mult_factor_o,
  // while pll_multiplier_o still echoes the raw field, unused codes included
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pll_bypass_o           <= 1'b0;
      adc_clock_halve_o      <= 1'b0;
      rx_clock_from_pll_o    <= 1'b0;
      synth_divide_by_five_o <= 1'b0;
      pll_multiplier_o       <= MUL_X1;
      pll_mult_factor_o      <= 5'h01;
    end else begin
      pll_bypass_o           <= clock_generation_config[CK_BYPASS];   // [RL10]
      adc_clock_halve_o      <= clock_generation_config[CK_ADC_DIV];  // [RL11]
      rx_clock_from_pll_o    <= clock_generation_config[CK_ALT];      // [RL12]
      synth_divide_by_five_o <= clock_generation_config[CK_DIV5];     // [RL13]
      pll_multiplier_o       <= clock_generation_config[CK_MUL_LSB +: CK_MUL_W];
      case (clock_generation_config[CK_MUL_LSB +: CK_MUL_W])
        MUL_X1:  pll_mult_factor_o <= 5'h01;              // [RL14]
        MUL_X2:  pll_mult_factor_o <= 5'h02;              // [RL14]
        MUL_X4:  pll_mult_factor_o <= 5'h04;              // [RL14]
        default: pll_mult_factor_o <= 5'h01;
      endcase
    end
  end

  // Read data mux
  // Decoded from the address while it waits on the bus; the word is
  // captured at the handshake, so a later register change cannot tear it
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rhit  = is_mapped(s_axi_araddr_i);
    case (s_axi_araddr_i)
      ADDR_INTERP:  next_rdata[INTERP_LSB +: INTERP_W] = interp_cfg;
      ADDR_IO_CFG:  next_rdata[7:0] = io_interface_config;
      ADDR_CLK_CFG: next_rdata[7:0] = clock_generation_config;
      ADDR_STATUS: begin
        next_rdata[ST_MODE_LSB +: 2] = iface_mode_o;
        next_rdata[ST_TX]            = tx_active_o;
        next_rdata[ST_LOOP]          = loopback_o;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read channel: one cycle accept, data next cycle
  // Only one read is ever open: arready stays low while rvalid stands and
  // returns in the cycle after the data is taken
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= next_rdata;
      s_axi_rresp_o   <= next_rhit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid_o) begin
      if (s_axi_rready_i) begin
        s_axi_rvalid_o  <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end else begin
      s_axi_arready_o <= 1'b1;
    end
  end
endmodule

// file: iccfg_bb.sv
// Baseband side: drives the direction pin from its own transmit request
module iccfg_bb (
  // Clock and request
  input  wire logic clock_i,
  input  wire logic tx_req_i,
  // Pin toward the block
  output logic      direction_pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pin changes just after an edge, high requests transmit
  always_ff @(posedge clock_i) begin
    direction_pin_o <= tx_req_i;
  end
endmodule

// file: iccfg_monitor.sv
module iccfg_monitor
  import iccfg_pkg::*;
(
  // Clock, reset and handshakes
  input wire logic           clock_i,
  input wire logic           rst_i,
  input wire logic           s_axi_awvalid_i,
  input wire logic           s_axi_awready_o,
  input wire logic           s_axi_wvalid_i,
  input wire logic           s_axi_wready_o,
  input wire logic           s_axi_bvalid_o,
  input wire logic           s_axi_arvalid_i,
  input wire logic           s_axi_arready_o,
  input wire logic           s_axi_rvalid_o,
  // Control outputs
  input wire iccfg_mode_type iface_mode_o,
  input wire logic           tx_active_o,
  input wire logic           loopback_o,
  input wire logic [1:0]     interp_rate_o,
  input wire logic           interp_x2_o,
  input wire logic           interp_x4_o,
  input wire logic           pll_bypass_o,
  input wire logic [2:0]     pll_multiplier_o,
  input wire logic [4:0]     pll_mult_factor_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  interp_decode_a:
    assert property ({interp_x4_o, interp_x2_o} == {interp_rate_o == INTERP_X4,
      interp_rate_o == INTERP_X2}) else $error("interpolation decode wrong");
  mult_factor_a:
    assert property (pll_mult_factor_o == (pll_multiplier_o == MUL_X2 ? 5'h2 :
      pll_multiplier_o == MUL_X4 ? 5'h4 : 5'h1)) else $error("multiplier factor wrong");
  loop_full_a:
    assert property (loopback_o |-> iface_mode_o == ICCFG_FULL_DUPLEX) else $error("loop mode");
  full_no_tx_a:
    assert property (iface_mode_o == ICCFG_FULL_DUPLEX |-> !tx_active_o)
      else $error("transmit in full duplex");
  mode_legal_a:
    assert property (iface_mode_o != 2'h3) else $error("mode code illegal");
  reset_state_a:
    assert property ($fell(rst_i) |-> iface_mode_o == ICCFG_FULL_DUPLEX && !loopback_o
      && !pll_bypass_o && pll_mult_factor_o == 5'h1) else $error("reset state wrong");
  write_resp_a:
    assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      |-> ##2 s_axi_bvalid_o) else $error("write response late");
  read_resp_a:
    assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o) else $error("rd late");
  read_block_a:
    assert property (s_axi_rvalid_o |-> !s_axi_arready_o) else $error("ar taken during read");
endmodule
bind iccfg_top iccfg_monitor u_mon (.*);

// file: testbench.sv
module testbench import iccfg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i, rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i;
  logic s_axi_rready_i, direction_pin_i, tx_req, s_axi_awready_o, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, tx_active_o, loopback_o;
  logic clone_mode_enable_o, interp_x2_o, interp_x4_o, pll_bypass_o, adc_clock_halve_o;
  logic rx_clock_from_pll_o, synth_divide_by_five_o;
  logic [7:0]     s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0]    s_axi_wdata_i, s_axi_rdata_o, rd;
  logic [3:0]     s_axi_wstrb_i;
  logic [1:0]     s_axi_bresp_o, s_axi_rresp_o, interp_rate_o, resp;
  logic [2:0]     pll_multiplier_o;
  logic [4:0]     pll_mult_factor_o;
  iccfg_mode_type iface_mode_o;
  wire [3:0]      clk_ctl = {pll_bypass_o, adc_clock_halve_o, rx_clock_from_pll_o,
                             synth_divide_by_five_o};
  int             failures = 0, check_count = 0, cyc = 0;
  iccfg_top u_dut (.*);
  iccfg_bb u_bb (.clock_i, .tx_req_i(tx_req), .direction_pin_o(direction_pin_i));
  // Clock
  initial begin
    clock_i = 0;
    forever #5 clock_i = ~clock_i;
  end
  task wrap_up;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      wrap_up;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Write: both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1;
    s_axi_wvalid_i <= 1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clock_i);
      aw_ok |= s_axi_awready_o === 1'b1;
      w_ok |= s_axi_wready_o === 1'b1;
      s_axi_awvalid_i <= !aw_ok;
      s_axi_wvalid_i <= !w_ok;
    end
    do @(posedge clock_i); while (s_axi_bvalid_o !== 1'b1);
    resp = s_axi_bresp_o;
    repeat (3) @(posedge clock_i);
  endtask
  task automatic rdr(input logic [7:0] a);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1;
    do @(posedge clock_i); while (s_axi_arready_o !== 1'b1);
    s_axi_arvalid_i <= 0;
    do @(posedge clock_i); while (s_axi_rvalid_o !== 1'b1);
    rd = s_axi_rdata_o;
    resp = s_axi_rresp_o;
  endtask
  task t_reset;
    chk(iface_mode_o, ICCFG_FULL_DUPLEX);
    chk(pll_mult_factor_o, 5'h1);
    chk(clk_ctl, 4'h0);
    chk(interp_rate_o, INTERP_BYPASS);
    rdr(ADDR_IO_CFG);
    chk(rd, 32'h10);
    chk(resp, RESP_OKAY);
    $display("test reset done");
  endtask
  task t_interp;
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_INTERP, i);
      chk({interp_x4_o, interp_x2_o, interp_rate_o}, {i[1:0], i[1:0]});
    end
    $display("test interpolation done");
  endtask
  // Entries: register value, pin, expected mode, expected direction
  task automatic t_io;
    logic [11:0] tb[6] = '{12'h108, 12'h04b, 12'h004, 12'h0a5, 12'h02c, 12'h15b};
    wr(ADDR_CLK_CFG, 8'h07);
    foreach (tb[i]) begin
      tx_req <= tb[i][3];
      wr(ADDR_IO_CFG, tb[i][11:4]);
      chk(iface_mode_o, tb[i][2:1]);
      chk(tx_active_o, tb[i][0]);
      chk(clone_mode_enable_o, tb[i][4]);
    end
    rdr(ADDR_STATUS);
    chk(rd[3:0], 4'h5);
    $display("test io modes done");
  endtask
  task t_loop;
    tx_req <= 0;
    wr(ADDR_IO_CFG, 8'h30);
    chk(resp, RESP_OKAY);
    chk({loopback_o, iface_mode_o}, {1'b1, ICCFG_FULL_DUPLEX});
    rdr(ADDR_STATUS);
    chk(rd[3:0], 4'h8);
    $display("test loopback done");
  endtask
  task automatic t_clock;
    logic [7:0] v[3] = '{8'hb8, 8'h01, 8'h02};
    logic [4:0] f[3] = '{5'h1, 5'h2, 5'h4};
    foreach (v[i]) begin
      wr(ADDR_CLK_CFG, v[i]);
      chk(clk_ctl, {v[i][7], v[i][5:3]});
      chk({pll_multiplier_o, pll_mult_factor_o}, {v[i][2:0], f[i]});
      rdr(ADDR_CLK_CFG);
      chk(rd, v[i]);
    end
    wr(8'h40, 32'hff);
    chk(resp, RESP_SLVERR);
    rdr(8'h40);
    chk(resp, RESP_SLVERR);
    chk(rd, 32'h0);
    chk(pll_mult_factor_o, 5'h4);
    $display("test clock done");
  endtask
  initial begin
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_arvalid_i, tx_req} = 0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 0;
    {s_axi_bready_i, s_axi_rready_i} = 2'h3;
    s_axi_wstrb_i = 4'hf;
    rst_i = 1;
    repeat (20) @(posedge clock_i);
    rst_i <= 0;
    @(posedge clock_i);
    t_reset;
    t_interp;
    t_io;
    t_loop;
    t_clock;
    wrap_up;
  end
endmodule
